// ===== include/viu_consts.svh
// Constants for the vectored interrupt unit: offsets, field positions, resets, timing.
// Assumes inclusion by bare name from package and design files.
`ifndef VIU_CONSTS_SVH
`define VIU_CONSTS_SVH

// ==========================================
// Source count and vector map
`define VIU_NUM_SRC 14
`define VIU_VEC_W 12
`define VIU_VEC_BASE 12'h0003
`define VIU_VEC_STEP 12'h0003
`define VIU_VEC_RESET 12'h0000
// Sources from this index on sit one extra gap above the plain step
`define VIU_VEC_GAP_IDX 3
`define VIU_VEC_GAP 12'h0006

// ==========================================
// Source indices, lowest index wins
`define VIU_SRC_EXT 0
`define VIU_SRC_PCHG 1
`define VIU_SRC_TICK 2

// ==========================================
// APB register byte offsets
`define VIU_OFF_STATUS_ONE 12'h000
`define VIU_OFF_STATUS_TWO 12'h004
`define VIU_OFF_MASK_ONE 12'h008
`define VIU_OFF_MASK_TWO 12'h00C
`define VIU_OFF_CTRL 12'h010
`define VIU_OFF_BACKUP 12'h014

// ==========================================
// Control register fields
`define VIU_CTRL_GIE_BIT 0
`define VIU_CTRL_LXT_BIT 1
`define VIU_CTRL_ACTIVE_BIT 2

// ==========================================
// Reset values
`define VIU_RST_FLAGS 14'h0000
`define VIU_RST_MASK 14'h0000

// ==========================================
// Noise filter: least pulse in system clock periods
`define VIU_FILT_CYCLES 8

`endif

// ===== include/viu_pkg.sv
// Types for the vectored interrupt unit.
// Assumes viu_consts.svh is on the include path.
`include "viu_consts.svh"

package viu_pkg;
   typedef logic [`VIU_NUM_SRC-1:0] viu_src_t;
   typedef logic [7:0] viu_byte_t;
   typedef logic [`VIU_VEC_W-1:0] viu_vec_t;
   typedef enum logic [1:0] {
      VIU_IDLE,
      VIU_VECTOR,
      VIU_SERVICE
   } viu_state_e;
endpackage

// ===== src/viu_pin_filter.sv
// Noise filter for the external interrupt pin with falling edge output.
// Assumes pin is synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "viu_consts.svh"

module viu_pin_filter #(
   parameter int FILT_CYCLES = `VIU_FILT_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Pin and mode
   input wire logic pin_i,
   input wire logic bypass_i,
   // Result
   output logic fall_o
);
   localparam int CW = $clog2(FILT_CYCLES + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic stable;
      logic prev;
      logic fall;
   } viu_filt_s;

   viu_filt_s q, d;

   always_comb begin
      d = q;
      d.fall = 1'b0;
      if (bypass_i) begin
         d.cnt = '0;
         d.stable = pin_i;
      end else if (pin_i == q.stable) begin
         d.cnt = '0;
      end else if (q.cnt == CW'(FILT_CYCLES - 1)) begin
         d.cnt = '0;
         d.stable = pin_i;
      end else begin
         d.cnt = q.cnt + CW'(1);
      end
      d.prev = d.stable;
      d.fall = q.prev & ~d.stable;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q <= '{cnt: '0, stable: 1'b1, prev: 1'b1, fall: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign fall_o = q.fall;
endmodule // viu_pin_filter

`default_nettype wire

// ===== src/viu_top.sv
// Vectored interrupt unit: flags, masks, global enable, priority vectoring, backup store.
// Assumes a core giving one-cycle instruction strobes and an APB master.
`timescale 1ns/1ps
`default_nettype none
`include "viu_consts.svh"

module viu_top
   import viu_pkg::*;
#(
   parameter int NUM_SRC = `VIU_NUM_SRC,
   parameter int FILT_CYCLES = `VIU_FILT_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Interrupt sources
   input wire logic ext_pin_i,
   input wire logic [NUM_SRC-1:0] src_event_i,
   // Core instruction strobes
   input wire logic global_irq_on_instr_i,
   input wire logic global_irq_off_instr_i,
   input wire logic return_from_isr_instr_i,
   // Core registers to save
   input wire viu_byte_t accumulator_i,
   input wire viu_byte_t core_status_reg_i,
   input wire viu_byte_t indirect_select_reg_i,
   // Fetch redirect
   output logic vector_valid_o,
   output viu_vec_t vector_addr_o,
   // Restore to core
   output logic restore_valid_o,
   output viu_byte_t accumulator_o,
   output viu_byte_t core_status_reg_o,
   output viu_byte_t indirect_select_reg_o,
   // Status
   output logic global_irq_en_o
);

   // ==========================================
   // State
   typedef struct packed {
      viu_src_t flags;
      viu_src_t mask;
      logic gie;
      logic low_freq_crystal_mode;
      logic active;
      viu_state_e st;
      logic vec_valid;
      viu_vec_t vec_addr;
      logic rst_valid;
      viu_byte_t bk_acc;
      viu_byte_t bk_stat;
      viu_byte_t bk_ind;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
   } viu_state_s;

   // ==========================================
   // Reset value
   localparam viu_state_s RST_STATE = '{
      flags: `VIU_RST_FLAGS,
      mask: `VIU_RST_MASK,
      gie: 1'b0,
      low_freq_crystal_mode: 1'b0,
      active: 1'b0,
      st: VIU_IDLE,
      vec_valid: 1'b0,
      vec_addr: `VIU_VEC_RESET,
      rst_valid: 1'b0,
      bk_acc: 8'h00,
      bk_stat: 8'h00,
      bk_ind: 8'h00,
      rdata: 32'h0000_0000,
      ready: 1'b0,
      slverr: 1'b0
   };

   viu_state_s q, d;
   logic ext_fall;
   viu_src_t events;
   viu_src_t pend;
   logic any_pend;
   logic [$clog2(NUM_SRC)-1:0] win;
   logic apb_acc;
   logic apb_wr;
   logic wr_st1;
   logic wr_st2;
   logic wr_m1;
   logic wr_m2;
   logic wr_ctl;
   viu_src_t flag_nxt;
   viu_src_t mask_nxt;
   viu_vec_t vec_tab [NUM_SRC];
   logic take_ret;
   logic take_irq;
   logic gie_nxt;
   logic [31:0] rd_word;
   logic rsp_err;
   logic [31:0] rsp_word;
   localparam int SEL_W = $clog2(NUM_SRC);

   // ==========================================
   // Decoding helpers
   function automatic logic addr_hit(input logic [11:0] a);
      unique case (a)
         `VIU_OFF_STATUS_ONE,
         `VIU_OFF_STATUS_TWO,
         `VIU_OFF_MASK_ONE,
         `VIU_OFF_MASK_TWO,
         `VIU_OFF_CTRL,
         `VIU_OFF_BACKUP: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   endfunction

   // Map skips two slots after the third source
   function automatic viu_vec_t vec_of(input logic [$clog2(NUM_SRC)-1:0] i);
      vec_of = `VIU_VEC_BASE + viu_vec_t'(i) * `VIU_VEC_STEP;
      if (i >= `VIU_VEC_GAP_IDX) begin
         vec_of = vec_of + `VIU_VEC_GAP;
      end
   endfunction

   // ==========================================
   // External pin filter
   viu_pin_filter #(
      .FILT_CYCLES(FILT_CYCLES)
   ) u_filter (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .pin_i(ext_pin_i),
      .bypass_i(q.low_freq_crystal_mode),
      .fall_o(ext_fall)
   );

   // ==========================================
   // Event gathering and priority
   always_comb begin
      events = src_event_i;
      events[`VIU_SRC_EXT] = ext_fall;
      events[`VIU_SRC_PCHG] = src_event_i[`VIU_SRC_PCHG] & q.mask[`VIU_SRC_PCHG];
   end

   assign pend = q.flags & q.mask;
   assign any_pend = |pend;

   always_comb begin
      win = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pend[i]) begin
            win = i[$clog2(NUM_SRC)-1:0];
         end
      end
   end

   assign apb_acc = psel_i & penable_i & ~q.ready;
   assign apb_wr = apb_acc & pwrite_i & addr_hit(paddr_i);

   // ==========================================
   // Register write selects
   assign wr_st1 = apb_wr && (paddr_i == `VIU_OFF_STATUS_ONE);
   assign wr_st2 = apb_wr && (paddr_i == `VIU_OFF_STATUS_TWO);
   assign wr_m1 = apb_wr && (paddr_i == `VIU_OFF_MASK_ONE);
   assign wr_m2 = apb_wr && (paddr_i == `VIU_OFF_MASK_TWO);
   assign wr_ctl = apb_wr && (paddr_i == `VIU_OFF_CTRL);

   // ==========================================
   // Per-source flag and mask, sources 0 to 7 in the first register pair
   for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
      localparam int RB = g % 8;
      logic clr;
      logic load;
      assign clr = ((g < 8) ? wr_st1 : wr_st2) & pwdata_i[RB];
      assign load = (g < 8) ? wr_m1 : wr_m2;
      // Set wins over a clear in the same cycle
      assign flag_nxt[g] = (q.flags[g] & ~clr) | events[g];
      assign mask_nxt[g] = load ? pwdata_i[RB] : q.mask[g];
   end

   // ==========================================
   // Fixed vector per source
   for (genvar g = 0; g < NUM_SRC; g++) begin : g_vec
      assign vec_tab[g] = vec_of(SEL_W'(g));
   end

   // ==========================================
   // Return and vectoring decisions
   assign take_ret = return_from_isr_instr_i & q.active & (q.st != VIU_VECTOR);
   // Return beats vectoring in the same cycle
   assign take_irq = q.gie & any_pend & ~take_ret & (q.st != VIU_VECTOR);

   // ==========================================
   // Global enable
   always_comb begin
      gie_nxt = q.gie;
      if (wr_ctl) begin
         gie_nxt = pwdata_i[`VIU_CTRL_GIE_BIT];
      end
      if (global_irq_off_instr_i) begin
         gie_nxt = 1'b0;
      end
      if (global_irq_on_instr_i) begin
         gie_nxt = 1'b1;
      end
      if (take_ret) begin
         gie_nxt = 1'b1;
      end else if (take_irq) begin
         gie_nxt = 1'b0;
      end
   end

   // ==========================================
   // Read data
   always_comb begin
      rd_word = '0;
      unique case (paddr_i)
         `VIU_OFF_STATUS_ONE: rd_word[7:0] = q.flags[7:0];
         `VIU_OFF_STATUS_TWO: rd_word[NUM_SRC-9:0] = q.flags[NUM_SRC-1:8];
         `VIU_OFF_MASK_ONE: rd_word[7:0] = q.mask[7:0];
         `VIU_OFF_MASK_TWO: rd_word[NUM_SRC-9:0] = q.mask[NUM_SRC-1:8];
         `VIU_OFF_CTRL: rd_word[2:0] = {q.active, q.low_freq_crystal_mode, q.gie};
         `VIU_OFF_BACKUP: rd_word[23:0] = {q.bk_ind, q.bk_stat, q.bk_acc};
         default: rd_word = '0;
      endcase
   end

   // ==========================================
   // APB response
   assign rsp_err = ~addr_hit(paddr_i);
   assign rsp_word = pwrite_i ? 32'h0000_0000 : rd_word;

   // ==========================================
   // Next state
   always_comb begin
      d = q;
      d.flags = flag_nxt;
      d.mask = mask_nxt;
      d.gie = gie_nxt;
      d.vec_valid = 1'b0;
      d.rst_valid = 1'b0;
      d.ready = 1'b0;
      d.slverr = 1'b0;
      if (wr_ctl) begin
         d.low_freq_crystal_mode = pwdata_i[`VIU_CTRL_LXT_BIT];
      end

      unique case (q.st)
         VIU_IDLE, VIU_SERVICE: begin
            if (take_ret) begin
               d.active = 1'b0;
               d.st = VIU_IDLE;
               d.rst_valid = 1'b1;
            end else if (take_irq) begin
               d.st = VIU_VECTOR;
               d.vec_addr = vec_tab[win];
               d.vec_valid = 1'b1;
               d.bk_acc = accumulator_i;
               d.bk_stat = core_status_reg_i;
               d.bk_ind = indirect_select_reg_i;
               d.active = 1'b1;
            end
         end
         VIU_VECTOR: begin
            d.st = VIU_SERVICE;
         end
         default: d.st = VIU_IDLE;
      endcase

      // APB answer in the cycle after the access phase opens
      if (apb_acc) begin
         d.ready = 1'b1;
         d.slverr = rsp_err;
         d.rdata = rsp_word;
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q <= RST_STATE;
      end else begin
         q <= d;
      end
   end

   // ==========================================
   // Outputs
   assign prdata_o = q.rdata;
   assign pready_o = q.ready;
   assign pslverr_o = q.slverr;
   assign vector_valid_o = q.vec_valid;
   assign vector_addr_o = q.vec_addr;
   assign restore_valid_o = q.rst_valid;
   assign accumulator_o = q.bk_acc;
   assign core_status_reg_o = q.bk_stat;
   assign indirect_select_reg_o = q.bk_ind;
   assign global_irq_en_o = q.gie;

endmodule // viu_top

`default_nettype wire

// ===== verification/viu_top_sva.sv
// Checker on the unit's top ports: enable, vectoring and restore timing.
// Assumes one clock domain; the bind follows the module.
`timescale 1ns/1ps
`default_nettype none
module viu_top_sva (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Strobes in
   input wire logic global_irq_on_instr_i,
   input wire logic global_irq_off_instr_i,
   input wire logic return_from_isr_instr_i,
   // Unit outputs
   input wire logic vector_valid_o,
   input wire viu_pkg::viu_vec_t vector_addr_o,
   input wire logic restore_valid_o,
   input wire viu_pkg::viu_byte_t accumulator_o,
   input wire logic global_irq_en_o
);
   import viu_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   // ========================
   // Enable, vectoring and return
   sequence s_pulse;
      vector_valid_o ##1 !vector_valid_o;
   endsequence
   a_vec_needs_gie: assert property (vector_valid_o |-> $past(global_irq_en_o))
      else $error("vector without enable");
   a_vec_drops_gie: assert property (vector_valid_o |-> !global_irq_en_o)
      else $error("enable kept on vector");
   a_vec_one_pulse: assert property (vector_valid_o |-> s_pulse)
      else $error("vector pulse too long");
   a_vec_addr_map: assert property (vector_valid_o |-> vector_addr_o % 3 == 0
      && vector_addr_o inside {[12'h003:12'h030]}
      && !(vector_addr_o inside {12'h00C, 12'h00F}))
      else $error("vector outside map");
   a_on_sets_gie: assert property (global_irq_on_instr_i |=> global_irq_en_o || vector_valid_o)
      else $error("enable not set");
   a_off_clr_gie: assert property (global_irq_off_instr_i && !global_irq_on_instr_i
      && !return_from_isr_instr_i |=> !global_irq_en_o)
      else $error("enable not cleared");
   a_ret_cause: assert property (restore_valid_o |-> $past(return_from_isr_instr_i)
      && global_irq_en_o)
      else $error("restore without return");
   a_ret_keeps_bkp: assert property (restore_valid_o |-> $stable(accumulator_o))
      else $error("backup moved on restore");
endmodule // viu_top_sva
bind viu_top viu_top_sva u_sva (.clk_i, .rstn_i, .global_irq_on_instr_i,
   .global_irq_off_instr_i, .return_from_isr_instr_i, .vector_valid_o, .vector_addr_o,
   .restore_valid_o, .accumulator_o, .global_irq_en_o);
`default_nettype wire

// ===== verification/viu_core_model.sv
// Core model: hands the unit its live registers, alters them in service, reloads on restore.
// Assumes one-cycle vector and restore pulses from the unit.
`timescale 1ns/1ps
`default_nettype none
module viu_core_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // From the unit
   input wire logic vec_i,
   input wire logic restore_i,
   input wire logic [23:0] bkp_i,
   // Live registers, indirect select, status, accumulator
   output logic [23:0] regs_o
);
   // ========================
   // Core register file
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         regs_o <= 24'h81_3c5a;
      end else if (restore_i) begin
         regs_o <= bkp_i;
      end else if (vec_i) begin
         // Service routine overwrites all three
         regs_o <= ~regs_o + 24'h01_0101;
      end
   end
endmodule // viu_core_model
`default_nettype wire

// ===== verification/tb_vectored_interrupt_unit.sv
// Testbench for the vectored interrupt unit: APB access, strobes, pin pulses, events.
// Assumes viu_pkg compiled first; the core model feeds the saved registers.
`timescale 1ns/1ps
`default_nettype none
module tb_vectored_interrupt_unit;
   import viu_pkg::*;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic ext_pin_i = 1'b1;
   logic [2:0] ins_v = 3'b000;
   logic [13:0] src_event_i = 14'h0000;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o, rdata, snap;
   logic pready_o, pslverr_o, lerr, vector_valid_o, restore_valid_o, global_irq_en_o;
   viu_vec_t vector_addr_o;
   wire [23:0] regs, bkp;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   always #4 clk_i = ~clk_i;
   viu_top dut (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
      .pready_o, .pslverr_o, .ext_pin_i, .src_event_i, .global_irq_on_instr_i(ins_v[0]),
      .global_irq_off_instr_i(ins_v[1]), .return_from_isr_instr_i(ins_v[2]),
      .accumulator_i(regs[7:0]), .core_status_reg_i(regs[15:8]),
      .indirect_select_reg_i(regs[23:16]), .vector_valid_o, .vector_addr_o, .restore_valid_o,
      .accumulator_o(bkp[7:0]), .core_status_reg_o(bkp[15:8]),
      .indirect_select_reg_o(bkp[23:16]), .global_irq_en_o);
   viu_core_model core (.clk_i, .rstn_i, .vec_i(vector_valid_o), .restore_i(restore_valid_o),
      .bkp_i(bkp), .regs_o(regs));
   // ========================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rdata = prdata_o;
      lerr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdata, e);
   endtask
   task automatic ins(input logic [2:0] v);
      ins_v <= v;
      @(posedge clk_i);
      ins_v <= 3'b000;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic pin(input int n);
      ext_pin_i <= 1'b0;
      repeat (n) @(posedge clk_i);
      ext_pin_i <= 1'b1;
      repeat (6) @(posedge clk_i);
   endtask
   task automatic wait_vec(input logic [11:0] e);
      int n;
      n = 0;
      while (vector_valid_o !== 1'b1 && n < 10) begin
         @(posedge clk_i);
         n++;
      end
      chk({19'h0, vector_valid_o, vector_addr_o}, {19'h0, 1'b1, e});
   endtask
   task automatic stop_test();
      if (err_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ========================
   // Sequence
   initial begin
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      for (int i = 0; i < 5; i++) rd(12'(4 * i), 32'h0);
      rd(12'h018, 32'h0);
      chk({31'h0, lerr}, 32'h1);
      src_event_i <= 14'h2006;
      @(posedge clk_i);
      src_event_i <= 14'h0000;
      rd(12'h000, 32'h4);
      rd(12'h004, 32'h20);
      apb(1'b1, 12'h008, 32'h4);
      apb(1'b1, 12'h00c, 32'h20);
      rd(12'h010, 32'h0);
      snap = {8'h0, regs};
      ins(3'b001);
      wait_vec(12'h009);
      rd(12'h010, 32'h4);
      rd(12'h014, snap);
      snap = {8'h0, regs};
      ins(3'b001);
      wait_vec(12'h009);
      rd(12'h014, snap);
      apb(1'b1, 12'h000, 32'h4);
      apb(1'b1, 12'h004, 32'h20);
      rd(12'h000, 32'h0);
      ins(3'b100);
      chk({8'h0, regs}, snap);
      chk({31'h0, global_irq_en_o}, 32'h1);
      rd(12'h010, 32'h1);
      ins(3'b010);
      chk({31'h0, global_irq_en_o}, 32'h0);
      rd(12'h010, 32'h0);
      apb(1'b1, 12'h008, 32'h1);
      pin(7);
      rd(12'h000, 32'h0);
      pin(8);
      rd(12'h000, 32'h1);
      ins(3'b001);
      wait_vec(12'h003);
      apb(1'b1, 12'h000, 32'h1);
      ins(3'b100);
      apb(1'b1, 12'h010, 32'h2);
      pin(2);
      apb(1'b1, 12'h008, 32'h2);
      src_event_i <= 14'h0002;
      @(posedge clk_i);
      src_event_i <= 14'h0000;
      rd(12'h000, 32'h3);
      apb(1'b1, 12'h008, 32'h0);
      src_event_i <= 14'h2000;
      @(posedge clk_i);
      src_event_i <= 14'h0000;
      ins(3'b001);
      wait_vec(12'h030);
      stop_test();
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         chk(32'h0, 32'h1);
         stop_test();
      end
   end
endmodule // tb_vectored_interrupt_unit
`default_nettype wire
